// ==== hdl/ppb_core.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Global transition bit is NOR of ports
// - Input differing from snapshot sets transition
// - Port register read clears its transition
// - Global flag clears after all flagged reads
// - Reset low abandons serial transfer, idles
// - Reset input acts as chip select
// - Config D0: reset restores port registers
// - Config D1: reset clears PWM/blink counters
// - Hardware reset leaves alert output unchanged
// - Port one latching active-low change alert
// - Reading ports 0x01-0x04 releases alert
// - Timeout/debounce always use internal timebase
// - Clock config D2 selects external clock
// - Clock config D3 outputs selected clock
// - Selected timebase divided by 32
// - 32-step PWM period, per-port duty
// - Duty zero low; 0111xxxx static high
// - Port PWM phases staggered by eighths
// - One shared blink period, incl. 32Hz
// - Per-port blink duty in sixteenths
// - Counters cleared at power-up, timebase off
// - Alert delayed to STOP; skipped if read
// - D5 selects PWM or blink; D4-D0 duty
// - Three-bit blink period select
module ppb_core
    import ppb_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       reset_in_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       read_seq_active,
    input  wire logic       stop_seen,
    input  wire logic [3:0] port_in,
    input  wire logic       ext_clock_in,
    output logic      [7:0] reg_rdata,
    output logic            serial_idle,
    output logic            chip_selected,
    output logic      [3:0] port_out,
    output logic            port_one_pin,
    output logic            buffered_clock_out,
    output logic            buffered_clock_oe,
    output logic            internal_timebase_tick
);
    import ppb_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] device_configuration;
    logic [7:0] clock_pin_configuration;
    logic [7:0] port_reg [NUM_PORTS];
    logic [3:0] snapshot;
    logic [3:0] transition;
    logic       alert_latched;
    logic       alert_pending;
    logic       rst_q;

    logic       tb_int;
    logic       tb_int_q;
    logic       ext_q;
    logic       sel_q;
    logic       sel_clk;
    logic       sel_rise;
    logic       tb_run;
    logic [TIMEBASE_DIV_WIDTH-1:0] div_cnt;
    logic [PWM_PHASE_WIDTH-1:0]    pwm_phase;
    logic [BLINK_CNT_WIDTH-1:0]    blink_cnt;
    logic       pwm_tick;

    logic       hw_rst;
    logic       port_rd_hit;
    logic [1:0] rd_idx;
    logic [3:0] change;
    logic [3:0] next_transition;
    logic [3:0] next_port_out;
    logic       alert_event;

    function automatic logic is_port_addr(input logic [7:0] a);
        return (a >= PORT_REG_FIRST_ADDR) && (a <= PORT_REG_LAST_ADDR);
    endfunction : is_port_addr

    function automatic logic [3:0] blink_phase16(input logic [BLINK_CNT_WIDTH-1:0] c,
                                                 input logic [2:0] sel);
        logic [3:0] r;
        r = 4'h0;
        unique case (sel)
            3'h0: r = c[12:9];
            3'h1: r = c[11:8];
            3'h2: r = c[10:7];
            3'h3: r = c[9:6];
            3'h4: r = c[8:5];
            3'h5: r = c[7:4];
            3'h6: r = c[6:3];
            3'h7: r = c[4:1];
        endcase
        return r;
    endfunction : blink_phase16

    // ------------------------------------------------------------------
    // Hardware reset input and chip select
    // ------------------------------------------------------------------
    // Chip select from reset pin
    assign hw_rst      = ~reset_in_n;
    assign rd_idx      = 2'(reg_addr - PORT_REG_FIRST_ADDR);
    assign port_rd_hit = reg_rd && reset_in_n && is_port_addr(reg_addr);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rst_q         <= 1'b0;
            serial_idle   <= 1'b1;
            chip_selected <= 1'b0;
        end else begin
            rst_q         <= hw_rst;
            serial_idle   <= hw_rst;
            chip_selected <= reset_in_n;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            device_configuration    <= DEVICE_CONFIGURATION_RESET;
            clock_pin_configuration <= CLOCK_PIN_CONFIGURATION_RESET;
        end else if (reg_wr && reset_in_n) begin
            // D4,D3 stored as written; master keeps them zero
            if (reg_addr == DEVICE_CONFIGURATION_ADDR)
                device_configuration <= reg_wdata;
            if (reg_addr == CLOCK_PIN_CONFIGURATION_ADDR)
                clock_pin_configuration <= reg_wdata;
        end
    end

    // Port registers; written here since restore must reach them
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_PORTS; i++)
                port_reg[i] <= PORT_REG_RESET;
        end else if (hw_rst && device_configuration[CFG_RST_RESTORE_BIT]) begin
            for (int i = 0; i < NUM_PORTS; i++)
                port_reg[i] <= PORT_REG_RESET;
        end else if (reg_wr && reset_in_n && is_port_addr(reg_addr)) begin
            port_reg[rd_idx] <= reg_wdata;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd && reset_in_n) begin
            if (reg_addr == DEVICE_CONFIGURATION_ADDR)
                reg_rdata <= {~|transition, device_configuration[6:0]};
            else if (reg_addr == CLOCK_PIN_CONFIGURATION_ADDR)
                reg_rdata <= clock_pin_configuration;
            else if (is_port_addr(reg_addr))
                reg_rdata <= {port_reg[rd_idx][7:2], transition[rd_idx], port_in[rd_idx]};
            else
                reg_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Transition detection
    // ------------------------------------------------------------------
    always_comb begin
        change          = 4'h0;
        next_transition = transition;
        for (int i = 0; i < NUM_PORTS; i++) begin
            // Differs from snapshot; a read captures its own port's level
            change[i] = port_reg[i][PORT_DIR_BIT] && (port_in[i] != snapshot[i]) &&
                        !(port_rd_hit && rd_idx == 2'(i));
            if (change[i])
                next_transition[i] = 1'b1;
        end
        // Read clears; the level it returns becomes the snapshot
        if (port_rd_hit)
            next_transition[rd_idx] = 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            snapshot   <= 4'h0;
            transition <= 4'h0;
        end else begin
            if (port_rd_hit)
                snapshot[rd_idx] <= port_in[rd_idx];
            // Global clears only when all flags cleared
            transition <= next_transition;
        end
    end

    // ------------------------------------------------------------------
    // Change alert on port one
    // ------------------------------------------------------------------
    always_comb begin
        alert_event = 1'b0;
        for (int i = 0; i < NUM_PORTS; i++)
            // Only a fresh transition alerts, so a release by reading another port sticks
            if (change[i] && !transition[i] && port_reg[i][PORT_INT_EN_BIT])
                alert_event = 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alert_latched <= 1'b0;
            alert_pending <= 1'b0;
        end else begin
            if (read_seq_active) begin
                if (alert_event)
                    alert_pending <= 1'b1;
                else if (port_rd_hit && ~|next_transition)
                    alert_pending <= 1'b0;
                if (port_rd_hit)
                    alert_latched <= 1'b0;
            end else begin
                alert_pending <= 1'b0;
                if (alert_event || (stop_seen && alert_pending))
                    alert_latched <= 1'b1;
                else if (port_rd_hit)
                    alert_latched <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset)
            port_one_pin <= 1'b1;
        else
            port_one_pin <= ~alert_latched;
    end

    // ------------------------------------------------------------------
    // Timebase selection and counters
    // ------------------------------------------------------------------
    // Timebase off until any port register is nonzero or clock output is enabled
    assign tb_run = clock_pin_configuration[CLK_OUT_EN_BIT] | (|(port_reg[0] | port_reg[1] |
                    port_reg[2] | port_reg[3]));

    ppb_timebase u_timebase (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .run      (tb_run),
        .tb_level (tb_int)
    );

    // External clock only for PWM, blink and the buffered clock output
    assign sel_clk  = clock_pin_configuration[CLK_EXT_SEL_BIT] ? ext_q : tb_int_q;
    assign sel_rise = sel_clk & ~sel_q;
    assign pwm_tick = sel_rise && (div_cnt == 5'h1F);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tb_int_q               <= 1'b0;
            ext_q                  <= 1'b0;
            sel_q                  <= 1'b0;
            internal_timebase_tick <= 1'b0;
        end else begin
            tb_int_q               <= tb_int;
            ext_q                  <= ext_clock_in;
            sel_q                  <= sel_clk;
            internal_timebase_tick <= tb_int & ~tb_int_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_cnt   <= '0;
            pwm_phase <= '0;
            blink_cnt <= '0;
        end else if (hw_rst && device_configuration[CFG_RST_COUNTER_BIT]) begin
            div_cnt   <= '0;
            pwm_phase <= '0;
            blink_cnt <= '0;
        end else if (sel_rise) begin
            div_cnt <= div_cnt + 5'h01;
            if (pwm_tick) begin
                pwm_phase <= pwm_phase + 5'h01;
                if (pwm_phase == 5'h1F)
                    blink_cnt <= blink_cnt + 13'h0001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Waveform generation
    // ------------------------------------------------------------------
    always_comb begin
        logic [4:0] ph;
        logic [3:0] bph;
        logic [7:0] r;
        ph            = '0;
        bph           = '0;
        r             = '0;
        next_port_out = 4'h0;
        // One blink phase for all ports
        // Period select field
        // Fast periods need the PWM phase bits below the blink count
        bph = blink_phase16({blink_cnt[7:0], pwm_phase},
                            device_configuration[CFG_BLINK_HI_BIT:CFG_BLINK_LO_BIT]);
        for (int i = 0; i < NUM_PORTS; i++) begin
            r  = port_reg[i];
            // Stagger by eighth per port
            ph = pwm_phase + 5'(i) * {2'b00, PHASE_STEP};
            if (r[6:4] == 3'b111)
                next_port_out[i] = 1'b1;
            else if (r[PORT_WAVE_BIT])
                next_port_out[i] = (bph < r[3:0]);
            else
                next_port_out[i] = (ph < r[PORT_DUTY_HI_BIT:0]);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            port_out           <= 4'h0;
            buffered_clock_out <= 1'b0;
            buffered_clock_oe  <= 1'b0;
        end else begin
            port_out           <= next_port_out;
            buffered_clock_out <= sel_clk;
            buffered_clock_oe  <= clock_pin_configuration[CLK_OUT_EN_BIT];
        end
    end
endmodule : ppb_core
`default_nettype wire

// ==== hdl/ppb_pkg.sv ====
package ppb_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] DEVICE_CONFIGURATION_ADDR    = 8'h26;
    localparam logic [7:0] CLOCK_PIN_CONFIGURATION_ADDR = 8'h27;
    localparam logic [7:0] PORT_REG_FIRST_ADDR          = 8'h01;
    localparam logic [7:0] PORT_REG_LAST_ADDR           = 8'h04;
    localparam int         NUM_PORTS                    = 4;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CFG_RST_RESTORE_BIT = 0;
    localparam int CFG_RST_COUNTER_BIT = 1;
    localparam int CFG_BLINK_LO_BIT    = 2;
    localparam int CFG_BLINK_HI_BIT    = 4;
    localparam int CFG_TRANSITION_BIT  = 7;
    localparam int CLK_EXT_SEL_BIT     = 2;
    localparam int CLK_OUT_EN_BIT      = 3;
    localparam int PORT_DIR_BIT        = 7;
    localparam int PORT_OUT_TYPE_BIT   = 6;
    localparam int PORT_WAVE_BIT       = 5;
    localparam int PORT_INT_EN_BIT     = 5;
    localparam int PORT_DUTY_HI_BIT    = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] DEVICE_CONFIGURATION_RESET    = 8'h00;
    localparam logic [7:0] CLOCK_PIN_CONFIGURATION_RESET = 8'h00;
    localparam logic [7:0] PORT_REG_RESET                = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          TIMEBASE_DIV_WIDTH = 5;
    localparam int          PWM_PHASE_WIDTH    = 5;
    localparam int          BLINK_CNT_WIDTH    = 13;
    localparam int          INT_TIMEBASE_HZ    = 32768;
    localparam int          REF_CLK_HZ         = 40000000;
    localparam int          INT_TIMEBASE_HALF  = REF_CLK_HZ / (2 * INT_TIMEBASE_HZ);
    localparam logic [9:0]  INT_HALF_CYCLES    = 10'(INT_TIMEBASE_HALF);
    localparam logic [2:0]  PHASE_STEP         = 3'h4;
endpackage : ppb_pkg

// ==== hdl/ppb_timebase.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Internal timebase: about 32 kHz square wave, enable-gated
// ----------------------------------------------------------------------
module ppb_timebase (
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic run,
    output var  logic tb_level
);
    import ppb_pkg::*;

    logic [9:0] half_cnt;

    // Held stopped at power-up so cascaded parts start in phase
    always_ff @(posedge ref_clk) begin
        if (reset || !run) begin
            half_cnt <= 10'h000;
            tb_level <= 1'b0;
        end else if (half_cnt == INT_HALF_CYCLES - 10'h001) begin
            half_cnt <= 10'h000;
            tb_level <= ~tb_level;
        end else begin
            half_cnt <= half_cnt + 10'h001;
        end
    end
endmodule : ppb_timebase
`default_nettype wire

// ==== tb/ppb_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module ppb_monitor
    import ppb_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       reset_in_n,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic       read_seq_active,
    input wire logic       stop_seen,
    input wire logic [3:0] port_in,
    input wire logic [7:0] reg_rdata,
    input wire logic       serial_idle,
    input wire logic       chip_selected,
    input wire logic       port_one_pin,
    input wire logic       buffered_clock_oe,
    input wire logic       internal_timebase_tick
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    logic port_rd;
    assign port_rd = reg_rd && reset_in_n && reg_addr >= PORT_REG_FIRST_ADDR && reg_addr <= PORT_REG_LAST_ADDR;

    // ------------------------------------------------------------------
    // Hardware reset input
    // ------------------------------------------------------------------
    idle_in_reset_a: assert property (!reset_in_n |=> serial_idle)
        else $error("serial side not idle under hardware reset");
    chip_deselect_a: assert property (!reset_in_n |=> !chip_selected)
        else $error("chip still selected with reset input low");
    alert_kept_a: assert property (!reset_in_n && $past(!reset_in_n) && !port_one_pin |=> !port_one_pin)
        else $error("alert cleared by hardware reset");
    // Reads are refused in reset, so the last answer must stand
    rdata_stands_a: assert property (!(reg_rd && reset_in_n) |=> $stable(reg_rdata))
        else $error("read data moved without an accepted read");

    // ------------------------------------------------------------------
    // Change alert
    // ------------------------------------------------------------------
    alert_release_a: assert property (port_rd && !port_one_pin && $stable(port_in) && !read_seq_active
        |=> ##[0:1] port_one_pin)
        else $error("alert not released by port read");
    no_alert_in_seq_a: assert property ($fell(port_one_pin) |-> !$past(read_seq_active, 2))
        else $error("alert asserted inside a read sequence");

    // ------------------------------------------------------------------
    // Clock options
    // ------------------------------------------------------------------
    clk_oe_write_a: assert property ($changed(buffered_clock_oe)
        |-> $past(reg_wr && reset_in_n && reg_addr == CLOCK_PIN_CONFIGURATION_ADDR, 2))
        else $error("clock output enable moved without a write");
    tick_pulse_a: assert property (internal_timebase_tick |=> !internal_timebase_tick [*8])
        else $error("internal timebase tick too frequent");

    alert_fall_c: cover property ($fell(port_one_pin));
    stop_alert_c: cover property (stop_seen ##[1:4] $fell(port_one_pin));
    reset_alert_c: cover property (!reset_in_n && !port_one_pin);
    clk_out_c: cover property ($rose(buffered_clock_oe));
endmodule : ppb_monitor

bind ppb_core ppb_monitor ppb_monitor_i (
    .ref_clk(ref_clk), .reset(reset), .reset_in_n(reset_in_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .read_seq_active(read_seq_active), .stop_seen(stop_seen), .port_in(port_in),
    .reg_rdata(reg_rdata), .serial_idle(serial_idle), .chip_selected(chip_selected),
    .port_one_pin(port_one_pin), .buffered_clock_oe(buffered_clock_oe),
    .internal_timebase_tick(internal_timebase_tick));
`default_nettype wire

// ==== tb/ppb_serial_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// Stands for the bus master behind the serial engine; requests change at falling edges
module ppb_serial_master
    import ppb_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       read_seq_active,
    output var  logic       stop_seen
);
    initial begin
        reg_wr          = 1'b0;
        reg_rd          = 1'b0;
        reg_addr        = 8'h00;
        reg_wdata       = 8'h00;
        read_seq_active = 1'b0;
        stop_seen       = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_addr  = a;
        reg_wdata = (a == DEVICE_CONFIGURATION_ADDR) ? (d & 8'hE7) : d;
        reg_wr    = 1'b1;
        @(negedge ref_clk);
        reg_wr    = 1'b0;
        // Released lines show a changed value, not the old one
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge ref_clk);
        d        = reg_rdata;
        reg_rd   = 1'b0;
        reg_addr = ~reg_addr;
    endtask : rd

    task automatic begin_seq;
        @(negedge ref_clk);
        read_seq_active = 1'b1;
    endtask : begin_seq

    task automatic end_seq;
        @(negedge ref_clk);
        read_seq_active = 1'b0;
        stop_seen       = 1'b1;
        @(negedge ref_clk);
        stop_seen       = 1'b0;
    endtask : end_seq
endmodule : ppb_serial_master
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ppb_pkg::*;
    logic       ref_clk, reset, reset_in_n, ext_clock_in, ext_run, prev_out;
    logic       reg_wr, reg_rd, read_seq_active, stop_seen, serial_idle, chip_selected;
    logic       port_one_pin, buffered_clock_out, buffered_clock_oe, internal_timebase_tick;
    logic [3:0] port_in, port_out, prev_po;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, d_prev;
    int         fails, tests_run, ext_cnt, rises, ticks, exp_ticks, r1, f2;
    int         hi [4];

    ppb_core ppb_core_i (.ref_clk(ref_clk), .reset(reset), .reset_in_n(reset_in_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .read_seq_active(read_seq_active),
        .stop_seen(stop_seen), .port_in(port_in), .ext_clock_in(ext_clock_in), .reg_rdata(reg_rdata),
        .serial_idle(serial_idle), .chip_selected(chip_selected), .port_out(port_out),
        .port_one_pin(port_one_pin), .buffered_clock_out(buffered_clock_out),
        .buffered_clock_oe(buffered_clock_oe), .internal_timebase_tick(internal_timebase_tick));
    ppb_serial_master ppb_serial_master_i (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .read_seq_active(read_seq_active),
        .stop_seen(stop_seen));

    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    // External clock at 1 MHz, stopped until the clock option is chosen
    always @(negedge ref_clk) begin
        if (ext_run) begin
            ext_cnt = ext_cnt + 1;
            if (ext_cnt == 20) begin
                ext_cnt      = 0;
                ext_clock_in = ~ext_clock_in;
            end
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : wait_n

    initial begin
        wait_n(60000);
        fails++;
        $display("mismatch at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        reset = 1'b1; reset_in_n = 1'b1; port_in = 4'h0; ext_clock_in = 1'b0; ext_run = 1'b0; ext_cnt = 0;
        wait_n(20);
        reset = 1'b0;
        // ------------------------------------------------------------------
        // Reset values
        // ------------------------------------------------------------------
        ppb_serial_master_i.rd(DEVICE_CONFIGURATION_ADDR, d); check(d, {1'b1, DEVICE_CONFIGURATION_RESET[6:0]});
        ppb_serial_master_i.rd(CLOCK_PIN_CONFIGURATION_ADDR, d); check(d, CLOCK_PIN_CONFIGURATION_RESET);
        ppb_serial_master_i.rd(8'h10, d); check(d, 8'h00);
        // ------------------------------------------------------------------
        // Transitions and alert
        // ------------------------------------------------------------------
        ppb_serial_master_i.wr(8'h01, 8'hA0);
        ppb_serial_master_i.wr(8'h02, 8'h80);
        ppb_serial_master_i.rd(8'h01, d);
        ppb_serial_master_i.rd(8'h02, d);
        check(port_one_pin, 1'b1);
        port_in = 4'h3;
        wait_n(4);
        check(port_one_pin, 1'b0);
        ppb_serial_master_i.rd(DEVICE_CONFIGURATION_ADDR, d); check(d[7], 1'b0);
        ppb_serial_master_i.rd(8'h01, d); check(d, 8'hA3);
        wait_n(2);
        check(port_one_pin, 1'b1);
        ppb_serial_master_i.rd(DEVICE_CONFIGURATION_ADDR, d); check(d[7], 1'b0);
        ppb_serial_master_i.rd(8'h02, d); check(d, 8'h83);
        ppb_serial_master_i.rd(DEVICE_CONFIGURATION_ADDR, d); check(d[7], 1'b1);
        ppb_serial_master_i.rd(8'h01, d); check(d, 8'hA1);
        // Change inside a read sequence waits for the stop
        ppb_serial_master_i.begin_seq();
        port_in = 4'h2;
        wait_n(4);
        check(port_one_pin, 1'b1);
        ppb_serial_master_i.end_seq();
        wait_n(4);
        check(port_one_pin, 1'b0);
        ppb_serial_master_i.rd(8'h01, d);
        // Change already read before the stop raises nothing
        ppb_serial_master_i.begin_seq();
        port_in = 4'h3;
        wait_n(4);
        ppb_serial_master_i.rd(8'h01, d);
        ppb_serial_master_i.end_seq();
        wait_n(4);
        check(port_one_pin, 1'b1);
        // ------------------------------------------------------------------
        // Hardware reset input
        // ------------------------------------------------------------------
        port_in = 4'h2;
        ppb_serial_master_i.wr(DEVICE_CONFIGURATION_ADDR, 8'h03);
        ppb_serial_master_i.rd(8'h10, d_prev);
        reset_in_n = 1'b0;
        ppb_serial_master_i.rd(DEVICE_CONFIGURATION_ADDR, d); check(d, d_prev);
        check(serial_idle, 1'b1);
        check(chip_selected, 1'b0);
        check(port_one_pin, 1'b0);
        reset_in_n = 1'b1;
        wait_n(2);
        check(chip_selected, 1'b1);
        ppb_serial_master_i.rd(8'h01, d); check(d[7:2], PORT_REG_RESET[7:2]);
        // ------------------------------------------------------------------
        // PWM from the external clock
        // ------------------------------------------------------------------
        // clock options set before any timing feature
        ppb_serial_master_i.wr(CLOCK_PIN_CONFIGURATION_ADDR, 8'h0C);
        ext_run = 1'b1;
        ppb_serial_master_i.wr(8'h01, 8'h00);
        ppb_serial_master_i.wr(8'h02, 8'h01);
        ppb_serial_master_i.wr(8'h03, 8'h1F);
        ppb_serial_master_i.wr(8'h04, 8'h70);
        wait_n(2000);
        hi = '{0, 0, 0, 0}; rises = 0; ticks = 0; prev_out = buffered_clock_out;
        prev_po = port_out; r1 = 0; f2 = 0;
        // One PWM period: 32 steps of 32 external periods of 40 cycles
        for (int n = 0; n < 40960; n++) begin
            @(negedge ref_clk);
            for (int k = 0; k < 4; k++) hi[k] += int'(port_out[k]);
            // Port 1 opens its one step and port 2 closes its one step at offsets of 4 and 8 steps
            if (port_out[1] && !prev_po[1]) r1 = n;
            if (!port_out[2] && prev_po[2]) f2 = n;
            prev_po = port_out;
            if (buffered_clock_out && !prev_out) rises++;
            prev_out = buffered_clock_out;
            ticks += int'(internal_timebase_tick);
        end
        exp_ticks = 40960 / (2 * INT_TIMEBASE_HALF);
        check(hi[0], 0);
        check(hi[1], 1280);
        check(hi[2], 31 * 1280);
        check(hi[3], 40960);
        check(buffered_clock_oe, 1'b1);
        check(rises, 1024);
        check(ticks >= exp_ticks && ticks <= exp_ticks + 1, 1'b1);
        check((r1 - f2 + 40960) % 40960, 5 * 1280);
        // Blink count is still in its first sixteenth, so duty 15 is high
        ppb_serial_master_i.wr(8'h01, 8'h2F);
        wait_n(3);
        check(port_out[0], 1'b1);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
